// [dv/clr_ncc_model.sv]
// control centre stand-in that answers contention logon bursts
// assumes logon_burst_req is a one-cycle pulse on aclk; bench sets delay >= 1
`timescale 1ns/100ps
module clr_ncc_model (
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // answer control from the bench
  input  wire logic       answer_en,
  input  wire logic [7:0] answer_delay,
  // logon link
  input  wire logic       logon_burst_req,
  output logic            logon_response = 1'b0
);
  logic [7:0] wait_reg;
  logic       armed_reg;

  // ==========================================================
  // answer
  // one answer per burst taken while answer_en is high, such a burst re-arms; delay kept below the wait limit
  always @(posedge aclk) begin
    logon_response <= 1'b0;
    if (!aresetn) begin
      armed_reg <= 1'b0;
      wait_reg  <= 8'h00;
    end else if (logon_burst_req && answer_en) begin
      armed_reg <= 1'b1;
      wait_reg  <= answer_delay;
    end else if (armed_reg) begin
      wait_reg <= wait_reg - 8'h01;
      if (wait_reg <= 8'h01) begin
        logon_response <= 1'b1;
        armed_reg      <= 1'b0;
      end
    end
  end
endmodule

// [dv/tb_contention_logon_retry.sv]
// self-checking bench for the contention logon retry core
// assumes clr_pkg constants and the hand-over register map
`timescale 1ns/100ps
module tb_contention_logon_retry import clr_pkg::*; ;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, irq, burst, resp;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, rty;
  logic [7:0]  lab, answer_delay = 8'h03;
  logic        answer_en = 1'b0;
  logic [33:0] wq[$], rq[$];
  int          num_errors = 0, checks_done = 0, seed = 30;
  int          cyc = 0, bursts = 0, last_b = 0, gap = 0, nb;

  always #50 aclk = ~aclk;

  clr_core clr_core_inst (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .logon_response(resp), .logon_burst_req(burst), .irq(irq)
  );

  clr_ncc_model clr_ncc_model_inst (
    .aclk(aclk), .aresetn(aresetn), .answer_en(answer_en), .answer_delay(answer_delay),
    .logon_burst_req(burst), .logon_response(resp)
  );

  // ==========================================================
  // checking and closing
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // monitor: oldest note against each bus answer
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready) check({bresp, 32'h0}, wq.pop_front());
    if (rvalid === 1'b1 && rready) check({rresp, rdata}, rq.pop_front());
  end

  // burst spacing, measured in cycles
  always @(posedge aclk) begin
    if (burst === 1'b1) begin
      gap = cyc - last_b;
      last_b = cyc;
      bursts++;
    end
    cyc++;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test();
  end

  // ==========================================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    wq.push_back({r, 32'h0});
    @(posedge aclk);
    awaddr  <= {24'h0, a};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // no cycle count assumed; only the watchdog ends a stuck wait
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    rq.push_back({r, d});
    @(posedge aclk);
    araddr  <= {24'h0, a};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask

  // whole descriptor: tag, length, then body bytes msb first
  task automatic desc(input logic [7:0] tag, input logic [7:0] len, input logic [7:0] sf,
                      input logic [31:0] tmo, input logic [7:0] lim, input logic [31:0] rb);
    logic [79:0] body;
    body = {sf, tmo, lim, rb};
    wr(ADDR_DESC, {24'h0, tag});
    wr(ADDR_DESC, {24'h0, len});
    for (int i = 0; i < len; i++) wr(ADDR_DESC, {24'h0, body[79-8*i -: 8]});
  endtask

  task automatic wait_irq(input int lim);
    for (int n = 0; n < lim; n++) begin
      @(posedge aclk);
      if (irq === 1'b1) return;
    end
    // a missed interrupt counts against the run
    num_errors++;
    $display("unexpected at %0t: interrupt never came", $time);
  endtask

  // ==========================================================
  // scenarios
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ADDR_TIMEOUT, TIMEOUT_RST);
    rd(ADDR_LIMIT, {24'h0, LIMIT_RST});
    rd(ADDR_RETRY, RETRY_RST);
    rd(ADDR_STATUS, 32'h0);
    rd(8'h28, 32'h0, RESP_SLVERR);
    wr(8'h2C, 32'h1, RESP_SLVERR);
    $display("test reset values done");

    lab = 8'($random(seed));
    rty = $random(seed);
    wr(ADDR_SF_SEL, {24'h0, lab});
    // a write with lane 0 off must leave the label alone
    wstrb <= 4'h0;
    wr(ADDR_SF_SEL, 32'h0000_0000);
    wstrb <= 4'hF;
    rd(ADDR_SF_SEL, {24'h0, lab});
    wr(ADDR_IRQ_MSK, 32'h1);
    desc(DESC_TAG_CONTENTION, 8'h0A, lab, 32'hFFFF_FFFE, 8'h07, rty);
    rd(ADDR_TIMEOUT, 32'hFFFF_FFFE);
    rd(ADDR_LIMIT, 32'h7);
    rd(ADDR_RETRY, rty);
    rd(ADDR_APPL_SF, {24'h0, lab});
    rd(ADDR_IRQ_ST, 32'h1);
    check({33'h0, irq}, 34'h1);
    wr(ADDR_IRQ_ST, 32'h1F);
    rd(ADDR_IRQ_ST, 32'h0);
    check({33'h0, irq}, 34'h0);
    // long wait limit must not expire early
    wr(ADDR_CTRL, 32'h1);
    repeat (40) @(posedge aclk);
    rd(ADDR_STATUS, 32'h1);
    wr(ADDR_CTRL, 32'h2);
    rd(ADDR_STATUS, 32'h0);
    $display("test descriptor apply done");

    desc(DESC_TAG_CONTENTION, 8'h0A, lab ^ 8'h01, 32'h10, 8'h02, 32'h4);
    rd(ADDR_IRQ_ST, 32'h2);
    wr(ADDR_IRQ_ST, 32'h1F);
    desc(DESC_TAG_CONTENTION, 8'h03, lab, 32'h10, 8'h02, 32'h4);
    rd(ADDR_IRQ_ST, 32'h2);
    wr(ADDR_IRQ_ST, 32'h1F);
    desc(DESC_TAG_CONTENTION, 8'h00, lab, 32'h10, 8'h02, 32'h4);
    rd(ADDR_IRQ_ST, 32'h2);
    wr(ADDR_IRQ_ST, 32'h1F);
    desc(8'h5A, 8'h0A, lab, 32'h10, 8'h02, 32'h4);
    rd(ADDR_IRQ_ST, 32'h0);
    rd(ADDR_TIMEOUT, 32'hFFFF_FFFE);
    $display("test descriptor reject done");

    rty = $random(seed) & 32'h0000_000F;
    desc(DESC_TAG_CONTENTION, 8'h0A, lab, 32'h10, 8'h02, rty);
    rd(ADDR_IRQ_ST, 32'h1);
    wr(ADDR_IRQ_ST, 32'h1F);
    wr(ADDR_IRQ_MSK, 32'h4);
    answer_en <= 1'b1;
    nb = bursts;
    wr(ADDR_CTRL, 32'h1);
    wait_irq(100);
    rd(ADDR_STATUS, 32'h4);
    rd(ADDR_IRQ_ST, 32'h4);
    check(34'(bursts - nb), 34'h1);
    wr(ADDR_IRQ_ST, 32'h1F);
    $display("test answered logon done");

    // first burst left unanswered, second answered
    answer_en <= 1'b0;
    nb = bursts;
    wr(ADDR_CTRL, 32'h1);
    while (bursts == nb) @(posedge aclk);
    answer_en <= 1'b1;
    wait_irq(200);
    rd(ADDR_STATUS, 32'h4);
    rd(ADDR_IRQ_ST, 32'hC);
    check(34'(bursts - nb), 34'h2);
    check(34'(gap >= 19 && gap <= 35 + rty), 34'h1);
    wr(ADDR_IRQ_ST, 32'h1F);
    $display("test collision retry done");

    answer_en <= 1'b0;
    wr(ADDR_IRQ_MSK, 32'h10);
    nb = bursts;
    wr(ADDR_CTRL, 32'h1);
    wait_irq(300);
    check({33'h0, irq}, 34'h1);
    rd(ADDR_STATUS, 32'h0000_0205);
    rd(ADDR_IRQ_ST, 32'h18);
    repeat (60) @(posedge aclk);
    check(34'(bursts - nb), 34'h2);
    $display("test give up done");
    stop_test();
  end
endmodule

// [hdl/clr_core.sv]
// contention logon retry: descriptor parser, retry engine, AXI4-Lite slave
// assumes logon_response is a one-cycle pulse synchronous to aclk
//
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/100ps
// Operation
// - first descriptor byte is an 8-bit tag selecting the descriptor kind
// - 8-bit length byte counts following bytes and bounds parsing
// - parameters apply only when the superframe label matches the selected one
// - after a burst, count response wait limit; expiry means collision
// - 32-bit interval counters cover the full documented duration
// - give up logon once failed attempts reach the attempt limit
// - after a collision wait random 0..retry bound before the next burst
// - body ends with 8-bit attempt limit then 32-bit retry bound
module clr_core import clr_pkg::*; (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // logon link
  input  wire logic        logon_response,
  output logic             logon_burst_req,
  // interrupt
  output logic             irq
);
  // ==========================================================
  // bus slave
  logic             awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
  logic             aw_held_reg, w_held_reg;
  logic [7:0]       awaddr_reg;
  logic [31:0]      wdata_reg, rdata_reg;
  logic             wlane0_reg;
  logic [1:0]       bresp_reg, rresp_reg;
  logic [IRQ_W-1:0] irq_st_reg, irq_msk_reg, ev;
  logic             irq_reg;

  wire aw_hs    = s_axi_awvalid & awready_reg;
  wire w_hs     = s_axi_wvalid & wready_reg;
  wire do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  wire ar_hs    = s_axi_arvalid & arready_reg;
  wire wr_en    = do_write & wlane0_reg;
  wire wr_ctrl  = wr_en & (awaddr_reg == ADDR_CTRL);
  wire wr_sf    = wr_en & (awaddr_reg == ADDR_SF_SEL);
  wire desc_wr  = wr_en & (awaddr_reg == ADDR_DESC);
  wire wr_ist   = wr_en & (awaddr_reg == ADDR_IRQ_ST);
  wire wr_msk   = wr_en & (awaddr_reg == ADDR_IRQ_MSK);
  wire [7:0] wb = wdata_reg[7:0];
  wire wr_hit   = (awaddr_reg <= ADDR_IRQ_MSK) && (awaddr_reg[1:0] == 2'b00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wlane0_reg  <= 1'b0;
    end else begin
      if (aw_hs) begin
        awaddr_reg  <= s_axi_awaddr[7:0];
        aw_held_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (w_hs) begin
        wdata_reg  <= s_axi_wdata;
        wlane0_reg <= s_axi_wstrb[0];
        w_held_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (do_write) begin
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
      end
      if (bvalid_reg & s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // ==========================================================
  // descriptor parser
  clr_parse_t  pst_reg;
  logic        tag_ok_reg, end_reg;
  logic [7:0]  len_reg, idx_reg, sh_sf_reg, sh_lim_reg, sf_sel_reg;
  logic [31:0] sh_to_reg, sh_rt_reg;
  logic [31:0] timeout_reg, retry_reg;
  logic [7:0]  limit_reg, appl_sf_reg;

  wire [7:0] idx_inc  = idx_reg + 8'h01;
  wire in_body        = desc_wr & (pst_reg == P_BODY);
  wire desc_end       = desc_wr & (((pst_reg == P_LEN) & (wb == 8'h00)) | ((pst_reg == P_BODY) & (idx_inc == len_reg)));
  wire body_full      = len_reg >= BODY_MIN_LEN;
  wire sf_match       = sh_sf_reg == sf_sel_reg;
  wire apply          = end_reg & tag_ok_reg & body_full & sf_match;
  wire reject         = end_reg & tag_ok_reg & ~(body_full & sf_match);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pst_reg    <= P_TAG;
      tag_ok_reg <= 1'b0;
      len_reg    <= 8'h00;
      idx_reg    <= 8'h00;
      end_reg    <= 1'b0;
    end else begin
      end_reg <= desc_end;
      if (desc_wr) begin
        case (pst_reg)
          P_TAG: begin
            tag_ok_reg <= (wb == DESC_TAG_CONTENTION);
            pst_reg    <= P_LEN;
          end
          P_LEN: begin
            len_reg <= wb;
            idx_reg <= 8'h00;
            pst_reg <= (wb == 8'h00) ? P_TAG : P_BODY;
          end
          P_BODY: begin
            idx_reg <= idx_inc;
            if (idx_inc == len_reg) pst_reg <= P_TAG;
          end
          default: pst_reg <= P_TAG;
        endcase
      end
    end
  end

  // shadow fields, msb first; surplus body bytes are skipped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sh_sf_reg  <= 8'h00;
      sh_lim_reg <= 8'h00;
      sh_to_reg  <= 32'h0000_0000;
      sh_rt_reg  <= 32'h0000_0000;
    end else if (in_body & tag_ok_reg) begin
      if (idx_reg == BODY_SF) sh_sf_reg <= wb;
      else if (idx_reg < BODY_LIM) sh_to_reg <= {sh_to_reg[23:0], wb};
      else if (idx_reg == BODY_LIM) sh_lim_reg <= wb;
      else if (idx_reg < BODY_MIN_LEN) sh_rt_reg <= {sh_rt_reg[23:0], wb};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timeout_reg <= TIMEOUT_RST;
      limit_reg   <= LIMIT_RST;
      retry_reg   <= RETRY_RST;
      appl_sf_reg <= 8'h00;
      sf_sel_reg  <= 8'h00;
    end else begin
      if (wr_sf) sf_sel_reg <= wb;
      if (apply) begin
        timeout_reg <= sh_to_reg;
        limit_reg   <= sh_lim_reg;
        retry_reg   <= sh_rt_reg;
        appl_sf_reg <= sh_sf_reg;
      end
    end
  end

  // ==========================================================
  // interval tick divider
  logic [7:0] div_reg;
  logic       tick_reg;
  wire        div_end = div_reg == PCR_DIV - 8'h01;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg  <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      div_reg  <= div_end ? 8'h00 : div_reg + 8'h01;
      tick_reg <= div_end;
    end
  end

  // ==========================================================
  // logon retry engine
  clr_state_t  st_reg, st_next;
  logic [31:0] cnt_reg, cnt_next, delay_reg, delay_next;
  logic [7:0]  loss_reg, loss_next;
  logic        burst_next;
  clr_rand_if  rnd ();

  clr_lfsr clr_lfsr_inst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .rnd     (rnd.gen)
  );

  // mask of all bits up to the bound's msb keeps draws uniform
  wire [31:0] m0      = retry_reg | (retry_reg >> 1);
  wire [31:0] m1      = m0 | (m0 >> 2);
  wire [31:0] m2      = m1 | (m1 >> 4);
  wire [31:0] m3      = m2 | (m2 >> 8);
  wire [31:0] rmask   = m3 | (m3 >> 16);
  wire [31:0] cand    = rnd.value & rmask;
  wire        start   = wr_ctrl & wb[CTRL_START];
  wire        abort   = wr_ctrl & wb[CTRL_ABORT];
  wire [31:0] cnt_inc = cnt_reg + 32'h0000_0001;
  wire [7:0]  loss_inc = loss_reg + 8'h01;
  wire        expired = cnt_reg >= timeout_reg;

  assign rnd.step = (st_reg == ST_DRAW);

  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    delay_next = delay_reg;
    loss_next  = loss_reg;
    burst_next = 1'b0;
    ev         = '0;
    ev[EV_APPLIED] = apply;
    ev[EV_REJECT]  = reject;
    case (st_reg)
      ST_IDLE, ST_DONE, ST_FAILED: begin
        if (start) begin
          st_next    = ST_WAIT;
          cnt_next   = 32'h0000_0000;
          loss_next  = 8'h00;
          burst_next = 1'b1;
        end
      end
      ST_WAIT: begin
        if (logon_response) begin
          st_next       = ST_DONE;
          loss_next     = 8'h00;
          ev[EV_RESP]   = 1'b1;
        end else if (expired) begin
          ev[EV_COLLIDE] = 1'b1;
          loss_next      = loss_inc;
          if (loss_inc >= limit_reg) begin
            st_next         = ST_FAILED;
            ev[EV_GIVE_UP]  = 1'b1;
          end else begin
            st_next = ST_DRAW;
          end
        end else if (tick_reg) begin
          cnt_next = cnt_inc;
        end
      end
      ST_DRAW: begin
        if (cand <= retry_reg) begin
          delay_next = cand;
          cnt_next   = 32'h0000_0000;
          st_next    = ST_BACKOFF;
        end
      end
      ST_BACKOFF: begin
        if (cnt_reg >= delay_reg) begin
          st_next    = ST_WAIT;
          cnt_next   = 32'h0000_0000;
          burst_next = 1'b1;
        end else if (tick_reg) begin
          cnt_next = cnt_inc;
        end
      end
      default: st_next = ST_IDLE;
    endcase
    if (abort) begin
      st_next    = ST_IDLE;
      burst_next = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg          <= ST_IDLE;
      cnt_reg         <= 32'h0000_0000;
      delay_reg       <= 32'h0000_0000;
      loss_reg        <= 8'h00;
      logon_burst_req <= 1'b0;
    end else begin
      st_reg          <= st_next;
      cnt_reg         <= cnt_next;
      delay_reg       <= delay_next;
      loss_reg        <= loss_next;
      logon_burst_req <= burst_next;
    end
  end

  // ==========================================================
  // interrupt status, set wins over write-one-to-clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_st_reg  <= '0;
      irq_msk_reg <= '0;
      irq_reg     <= 1'b0;
    end else begin
      irq_st_reg <= (irq_st_reg & ~(wr_ist ? wb[IRQ_W-1:0] : '0)) | ev;
      if (wr_msk) irq_msk_reg <= wb[IRQ_W-1:0];
      irq_reg <= |(irq_st_reg & irq_msk_reg);
    end
  end

  // ==========================================================
  // read path
  wire [7:0]  ra     = s_axi_araddr[7:0];
  wire [31:0] status = {16'h0000, loss_reg, 5'h00, st_reg};
  wire [31:0] rd_mux =
    (ra == ADDR_SF_SEL)  ? {24'h00_0000, sf_sel_reg} :
    (ra == ADDR_STATUS)  ? status :
    (ra == ADDR_TIMEOUT) ? timeout_reg :
    (ra == ADDR_LIMIT)   ? {24'h00_0000, limit_reg} :
    (ra == ADDR_RETRY)   ? retry_reg :
    (ra == ADDR_APPL_SF) ? {24'h00_0000, appl_sf_reg} :
    (ra == ADDR_IRQ_ST)  ? {27'h000_0000, irq_st_reg} :
    (ra == ADDR_IRQ_MSK) ? {27'h000_0000, irq_msk_reg} : 32'h0000_0000;
  wire rd_hit = (ra <= ADDR_IRQ_MSK) && (ra[1:0] == 2'b00);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else if (ar_hs) begin
      rdata_reg   <= rd_mux;
      rresp_reg   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rvalid_reg  <= 1'b1;
      arready_reg <= 1'b0;
    end else if (rvalid_reg & s_axi_rready) begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign irq           = irq_reg;

  // ==========================================================
  // checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_tag_select: assert property (desc_wr && pst_reg == P_TAG |=> tag_ok_reg == ($past(wb) == DESC_TAG_CONTENTION))
    else $error("tag decode wrong");
  a_len_bound: assert property (pst_reg == P_BODY |-> idx_reg < len_reg)
    else $error("body index past length");
  a_label_gate: assert property (timeout_reg != $past(timeout_reg) |-> $past(sf_match && end_reg))
    else $error("parameters applied for other superframe");
  a_timeout_collide: assert property (st_reg == ST_WAIT && expired && !logon_response |=> irq_st_reg[EV_COLLIDE]
    && st_reg != ST_WAIT)
    else $error("expiry not treated as collision");
  a_counter_range: assert property (st_reg == ST_WAIT |-> cnt_reg <= timeout_reg)
    else $error("wait counter overran limit");
  a_give_up: assert property (st_reg == ST_WAIT ##1 st_reg == ST_FAILED |-> loss_reg >= limit_reg
    && loss_reg == $past(loss_reg) + 8'h01)
    else $error("gave up at wrong loss count");
  a_backoff_bound: assert property (st_reg == ST_BACKOFF |-> delay_reg <= retry_reg)
    else $error("back-off beyond bound");
  a_retry_burst: assert property (st_reg == ST_BACKOFF && cnt_reg >= delay_reg && !abort |=> logon_burst_req
    && st_reg == ST_WAIT)
    else $error("no burst after back-off");
  a_field_order: assert property (apply |=> retry_reg == $past(sh_rt_reg) && limit_reg == $past(sh_lim_reg))
    else $error("descriptor tail fields misplaced");
  a_resp_clears: assert property (st_reg == ST_WAIT && logon_response && !abort |=> loss_reg == 8'h00
    && st_reg == ST_DONE)
    else $error("response did not clear losses");

  c_applied: cover property (apply);
  c_done: cover property (st_reg == ST_WAIT ##1 st_reg == ST_DONE);
  c_retry: cover property (st_reg == ST_BACKOFF ##1 st_reg == ST_WAIT);
  c_failed: cover property (st_reg == ST_FAILED);
endmodule

// [hdl/clr_lfsr.sv]
// 32-bit galois pseudo-random generator
// assumes the user raises step while it consumes values
`timescale 1ns/100ps
module clr_lfsr import clr_pkg::*; (
  // clock and reset
  input wire logic   aclk,
  input wire logic   aresetn,
  // random words
  clr_rand_if.gen    rnd
);
  logic [31:0] lfsr_reg;
  wire  [31:0] lfsr_next = {1'b0, lfsr_reg[31:1]} ^ (lfsr_reg[0] ? LFSR_TAPS : 32'h0000_0000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_reg <= LFSR_SEED;
    end else if (rnd.step) begin
      lfsr_reg <= lfsr_next;
    end
  end

  assign rnd.value = lfsr_reg;
endmodule

// [shared/clr_pkg.sv]
// constants, states and register map of the contention logon retry block
// assumes a 10 MHz aclk and a 32-bit AXI4-Lite register port
package clr_pkg;
  // ==========================================================
  // register byte addresses, low eight address bits decoded
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_SF_SEL  = 8'h04;
  localparam logic [7:0] ADDR_DESC    = 8'h08;
  localparam logic [7:0] ADDR_STATUS  = 8'h0C;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h10;
  localparam logic [7:0] ADDR_LIMIT   = 8'h14;
  localparam logic [7:0] ADDR_RETRY   = 8'h18;
  localparam logic [7:0] ADDR_APPL_SF = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h24;
  // ==========================================================
  // field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_ABORT = 1;
  localparam int STAT_LOSS  = 8;
  localparam int IRQ_W      = 5;
  localparam int EV_APPLIED = 0;
  localparam int EV_REJECT  = 1;
  localparam int EV_RESP    = 2;
  localparam int EV_COLLIDE = 3;
  localparam int EV_GIVE_UP = 4;
  // ==========================================================
  // descriptor layout, body byte index after the length byte
  localparam logic [7:0] DESC_TAG_CONTENTION = 8'hA5;
  localparam logic [7:0] BODY_SF      = 8'h00;
  localparam logic [7:0] BODY_LIM     = 8'h05;
  localparam logic [7:0] BODY_MIN_LEN = 8'h0A;
  // ==========================================================
  // reset values and timing
  localparam logic [31:0] TIMEOUT_RST = 32'h0000_1000;
  localparam logic [7:0]  LIMIT_RST   = 8'h03;
  localparam logic [31:0] RETRY_RST   = 32'h0000_0100;
  localparam logic [31:0] LFSR_SEED   = 32'h1ACE_B00C;
  localparam logic [31:0] LFSR_TAPS   = 32'h8020_0003;
  localparam logic [7:0]  PCR_DIV     = 8'h01;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  // ==========================================================
  typedef enum logic [2:0] {ST_IDLE, ST_WAIT, ST_DRAW, ST_BACKOFF, ST_DONE, ST_FAILED} clr_state_t;
  typedef enum logic [1:0] {P_TAG, P_LEN, P_BODY} clr_parse_t;
endpackage

// [shared/clr_rand_if.sv]
// random word carrier between the core and its generator
// assumes one clock shared by both ends
`timescale 1ns/100ps
interface clr_rand_if;
  logic        step;
  logic [31:0] value;
  modport gen  (input step, output value);
  modport user (output step, input value);
endinterface
